/* common/alc_pkg.sv */
// Package of constants and carrier types for the alert, limit and calibration register bank.
// Behaviour
// - Only highest enabled limit function is compared
// - Shunt above threshold asserts alert when enabled
// - Shunt below threshold asserts alert when enabled
// - Bus above threshold asserts alert when enabled
// - Bus below threshold asserts alert when enabled
// - Power above threshold asserts alert when enabled
// - Conversion ready asserts alert when enabled
// - Alert flag shows an enabled function active
// - Ready flag sets when conversion cycle completes
// - Ready flag clears on select read, or on config write outside power-down
// - Overflow flag marks invalid current or power
// - Sense bit chooses active low or high alert
// - Transparent mode releases alert when condition ends
// - Latch mode holds alert until select read
// - Threshold register is the comparison value
// - Calibration stores all 16 bits, only the low 15 drive the output
// - Maker register returns a fixed code
// - Die register returns device and revision codes
// - Calibration, select and threshold reset to zero
// - Shunt result compared as signed value
// - Bus result compared as non-negative value
// - Config write restarts conversion with new settings
package alc_pkg;
    localparam logic [7:0]  ALC_ADDR_CAL   = 8'h05;
    localparam logic [7:0]  ALC_ADDR_SEL   = 8'h06;
    localparam logic [7:0]  ALC_ADDR_THR   = 8'h07;
    localparam logic [7:0]  ALC_ADDR_MAKER = 8'hfe;
    localparam logic [7:0]  ALC_ADDR_DIE   = 8'hff;
    localparam int          ALC_B_SOL      = 15;
    localparam int          ALC_B_SUL      = 14;
    localparam int          ALC_B_BOL      = 13;
    localparam int          ALC_B_BUL      = 12;
    localparam int          ALC_B_POL      = 11;
    localparam int          ALC_B_CONVERSION_READY_ALERT_ENABLE     = 10;
    localparam int          ALC_B_AFF      = 4;
    localparam int          ALC_B_CONVERSION_READY_FLAG     = 3;
    localparam int          ALC_B_OVF      = 2;
    localparam int          ALC_B_SENSE    = 1;
    localparam int          ALC_B_LATCH    = 0;
    localparam logic [15:0] ALC_CAL_MASK   = 16'h7fff;
    localparam logic [15:0] ALC_SEL_WMASK  = 16'hfc03;
    localparam logic [15:0] ALC_RST_VAL    = 16'h0000;
    localparam logic [2:0]  ALC_MODE_OFF_A = 3'h0;
    localparam logic [2:0]  ALC_MODE_OFF_B = 3'h4;
    // Register access request from the serial transaction layer.
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } alc_req_t;
    // One finished conversion from the converter.
    typedef struct packed {
        logic        done;
        logic        ovf;
        logic [15:0] shunt;
        logic [15:0] bus;
        logic [15:0] power;
    } alc_conv_t;
    typedef enum logic [2:0] {
        ALC_F_NONE, ALC_F_SOL, ALC_F_SUL, ALC_F_BOL, ALC_F_BUL, ALC_F_POL
    } alc_func_t;
endpackage

/* core/alc_limit_cmp.sv */
`timescale 1ns/1ps
// Priority selector and limit comparator for the alert functions.
module alc_limit_cmp
    import alc_pkg::*;
(
    // Selection and threshold
    input  wire logic [15:0] sel,
    input  wire logic [15:0] thr,
    // Conversion results
    input  wire alc_conv_t   conv,
    // Result
    output alc_func_t        func,
    output logic             hit
);
    always_comb begin
        func = ALC_F_NONE;
        if (sel[ALC_B_SOL]) begin
            func = ALC_F_SOL;
        end else if (sel[ALC_B_SUL]) begin
            func = ALC_F_SUL;
        end else if (sel[ALC_B_BOL]) begin
            func = ALC_F_BOL;
        end else if (sel[ALC_B_BUL]) begin
            func = ALC_F_BUL;
        end else if (sel[ALC_B_POL]) begin
            func = ALC_F_POL;
        end
    end
    always_comb begin
        unique case (func)
            ALC_F_SOL: hit = $signed(conv.shunt) > $signed(thr);
            ALC_F_SUL: hit = $signed(conv.shunt) < $signed(thr);
            ALC_F_BOL: hit = {1'b0, conv.bus[14:0]} > thr;
            ALC_F_BUL: hit = {1'b0, conv.bus[14:0]} < thr;
            ALC_F_POL: hit = conv.power > thr;
            default:   hit = 1'b0;
        endcase
    end
endmodule

/* core/alc_id_rom.sv */
`timescale 1ns/1ps
// Read-only identification words.
module alc_id_rom #(
    // Arbitrary neutral identification values.
    parameter logic [15:0] MAKER_CODE = 16'h0a5a,
    parameter logic [11:0] DEVICE_CODE = 12'h123,
    parameter logic [3:0]  REV_CODE   = 4'h1
) (
    // Identification words
    output logic [15:0] maker_code_bits,
    output logic [15:0] die_code
);
    assign maker_code_bits = MAKER_CODE;
    assign die_code = {DEVICE_CODE, REV_CODE};
endmodule

/* core/alc_regs.sv */
`timescale 1ns/1ps
// Register bank with alert selection, flags, threshold, calibration and identification.
module alc_regs
    import alc_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // Register access
    input  wire alc_req_t    req,
    output logic [15:0]      rdata_q,
    // Configuration register write seen by the bank
    input  wire logic        cfg_wr,
    input  wire logic [2:0]  cfg_mode,
    // Converter
    input  wire alc_conv_t   conv,
    output logic             conv_restart_q,
    // Alert pin and calibration
    output logic             alert_q,
    output logic [14:0]      calibration_value_q
);
    logic [15:0] sel_q;
    logic [15:0] thr_q;
    logic [14:0] cal_q;
    logic        cal_rsv_q;
    logic        conversion_ready_flag_q;
    logic        ovf_q;
    logic        aff_q;
    logic        hit_q;
    logic        hit;
    alc_func_t   func;
    logic [15:0] maker_w;
    logic [15:0] die_w;
    logic        sel_rd;
    logic        pwr_down;
    logic        src_now;
    logic        aff_d;
    logic [15:0] sel_view;

    alc_limit_cmp u_cmp (
        .sel  (sel_q),
        .thr  (thr_q),
        .conv (conv),
        .func (func),
        .hit  (hit)
    );

    alc_id_rom u_id (
        .maker_code_bits (maker_w),
        .die_code        (die_w)
    );

    assign sel_rd   = req.rd && (req.addr == ALC_ADDR_SEL);
    assign pwr_down = (cfg_mode == ALC_MODE_OFF_A) || (cfg_mode == ALC_MODE_OFF_B);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sel_q     <= ALC_RST_VAL;
            thr_q     <= ALC_RST_VAL;
            cal_q     <= 15'h0000;
            cal_rsv_q <= 1'b0;
        end else if (req.wr) begin
            if (req.addr == ALC_ADDR_SEL) begin
                sel_q <= req.wdata & ALC_SEL_WMASK;
            end
            if (req.addr == ALC_ADDR_THR) begin
                thr_q <= req.wdata;
            end
            if (req.addr == ALC_ADDR_CAL) begin
                cal_q     <= req.wdata[14:0];
                cal_rsv_q <= req.wdata[15];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            hit_q <= 1'b0;
        end else if (conv.done) begin
            hit_q <= hit;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            conversion_ready_flag_q <= 1'b0;
        end else if (conv.done) begin
            conversion_ready_flag_q <= 1'b1;
        end else if (sel_rd || (cfg_wr && !pwr_down)) begin
            conversion_ready_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ovf_q <= 1'b0;
        end else if (conv.done) begin
            ovf_q <= conv.ovf;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            conv_restart_q <= 1'b0;
        end else begin
            conv_restart_q <= cfg_wr;
        end
    end

    always_comb begin
        src_now = hit_q || (sel_q[ALC_B_CONVERSION_READY_ALERT_ENABLE] && conversion_ready_flag_q);
        if (sel_q[ALC_B_LATCH]) begin
            aff_d = src_now || (aff_q && !sel_rd);
        end else begin
            aff_d = src_now;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            aff_q <= 1'b0;
        end else begin
            aff_q <= aff_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            alert_q <= 1'b1;
        end else begin
            alert_q <= sel_q[ALC_B_SENSE] ? aff_d : !aff_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            calibration_value_q <= 15'h0000;
        end else begin
            calibration_value_q <= cal_q;
        end
    end

    always_comb begin
        sel_view = sel_q;
        sel_view[ALC_B_AFF]  = aff_q;
        sel_view[ALC_B_CONVERSION_READY_FLAG] = conversion_ready_flag_q;
        sel_view[ALC_B_OVF]  = ovf_q;
    end

    // Read data is registered; an unmapped address reads zero.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rdata_q <= 16'h0000;
        end else if (req.rd) begin
            unique case (req.addr)
                ALC_ADDR_CAL:   rdata_q <= {cal_rsv_q, cal_q};
                ALC_ADDR_SEL:   rdata_q <= sel_view;
                ALC_ADDR_THR:   rdata_q <= thr_q;
                ALC_ADDR_MAKER: rdata_q <= maker_w;
                ALC_ADDR_DIE:   rdata_q <= die_w;
                default:        rdata_q <= 16'h0000;
            endcase
        end
    end

    // Assertions.
    sequence ready_clear_s;
        sel_rd && !conv.done;
    endsequence

    ready_set_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        conv.done |=> conversion_ready_flag_q)
        else $error("ready flag not set after conversion");
    ready_clr_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        ready_clear_s |=> !conversion_ready_flag_q)
        else $error("ready flag not cleared by select read");
    sense_low_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (!sel_q[ALC_B_SENSE] && aff_d) |=> !alert_q)
        else $error("active low alert not driven low");
    latch_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (sel_q[ALC_B_LATCH] && aff_q && !sel_rd) |=> aff_q)
        else $error("latched alert dropped without read");
    transp_rel_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (!sel_q[ALC_B_LATCH] && !src_now) |=> !aff_q)
        else $error("transparent alert not released");
    ovf_track_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        conv.done |=> (ovf_q == $past(conv.ovf)))
        else $error("overflow flag mismatch");
    conversion_ready_alert_enable_alert_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (sel_q[ALC_B_CONVERSION_READY_ALERT_ENABLE] && conversion_ready_flag_q) |=> aff_q)
        else $error("ready alert not raised");
    prio_sol_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        sel_q[ALC_B_SOL] |-> (func == ALC_F_SOL))
        else $error("shunt over function lost priority");
    restart_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        cfg_wr |=> conv_restart_q)
        else $error("restart not issued after config write");

    // Named steps shared by the properties below.
    sequence conv_hit_s;
        conv.done && hit;
    endsequence
    sequence hit_open_s;
        hit_q && !sel_q[ALC_B_LATCH];
    endsequence
    sequence sel_write_s;
        req.wr && (req.addr == ALC_ADDR_SEL);
    endsequence
    sequence thr_write_s;
        req.wr && (req.addr == ALC_ADDR_THR);
    endsequence
    sequence cal_write_s;
        req.wr && (req.addr == ALC_ADDR_CAL);
    endsequence
    sequence cfg_clear_s;
        cfg_wr && !pwr_down && !conv.done;
    endsequence

    // A limit hit is only taken at the end of a conversion.
    hit_capture_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        conv_hit_s |=> hit_q)
        else $error("limit hit not captured at conversion end");
    hit_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        !conv.done |=> $stable(hit_q))
        else $error("limit hit changed between conversions");
    alert_path_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (conv_hit_s ##1 hit_open_s) |=> aff_q)
        else $error("limit hit did not raise the alert flag");

    // Flag follows its sources.
    flag_source_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        src_now |=> aff_q)
        else $error("alert flag missing for an active source");
    latch_rel_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (sel_q[ALC_B_LATCH] && sel_rd && !src_now) |=> !aff_q)
        else $error("latched alert not released by select read");

    // Pin level against the sense bit.
    sense_high_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (sel_q[ALC_B_SENSE] && aff_d) |=> alert_q)
        else $error("active high alert not driven high");
    idle_high_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (!sel_q[ALC_B_SENSE] && !aff_d) |=> alert_q)
        else $error("idle active low alert not high");
    idle_low_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (sel_q[ALC_B_SENSE] && !aff_d) |=> !alert_q)
        else $error("idle active high alert not low");

    // Writable fields take the written value.
    sel_rsv_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        1'b1 |-> ((sel_q & ~ALC_SEL_WMASK) == ALC_RST_VAL))
        else $error("reserved select bits not zero");
    sel_write_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        sel_write_s |=> (sel_q == ($past(req.wdata) & ALC_SEL_WMASK)))
        else $error("select write not stored");
    thr_write_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        thr_write_s |=> (thr_q == $past(req.wdata)))
        else $error("threshold write not stored");
    cal_write_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        cal_write_s |=> ({cal_rsv_q, cal_q} == $past(req.wdata)))
        else $error("calibration write not stored");
    cal_out_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        1'b1 |=> (calibration_value_q == $past(cal_q)))
        else $error("calibration output does not follow register");

    // Ready flag holds, reads and clears.
    ready_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (!conv.done && !sel_rd && !cfg_wr) |=> $stable(conversion_ready_flag_q))
        else $error("ready flag changed without cause");
    sel_read_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        sel_rd |=> (rdata_q[ALC_B_CONVERSION_READY_FLAG] == $past(conversion_ready_flag_q)))
        else $error("select read lost the ready flag");
    cfg_clr_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        cfg_clear_s |=> !conversion_ready_flag_q)
        else $error("ready flag not cleared by config write");
    pwr_keep_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (cfg_wr && pwr_down && conversion_ready_flag_q && !sel_rd) |=> conversion_ready_flag_q)
        else $error("power down write cleared ready flag");

    // Overflow and restart.
    ovf_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        !conv.done |=> $stable(ovf_q))
        else $error("overflow flag changed between conversions");
    restart_pulse_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        !cfg_wr |=> !conv_restart_q)
        else $error("restart raised without config write");

    // Priority among the limit functions.
    prio_sul_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (sel_q[ALC_B_SOL:ALC_B_SUL] == 2'b01) |-> (func == ALC_F_SUL))
        else $error("shunt under function lost priority");
    prio_bol_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (sel_q[ALC_B_SOL:ALC_B_BOL] == 3'b001) |-> (func == ALC_F_BOL))
        else $error("bus over function lost priority");
    prio_bul_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (sel_q[ALC_B_SOL:ALC_B_BUL] == 4'b0001) |-> (func == ALC_F_BUL))
        else $error("bus under function lost priority");
    prio_pol_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (sel_q[ALC_B_SOL:ALC_B_POL] == 5'b00001) |-> (func == ALC_F_POL))
        else $error("power over function lost priority");
    prio_none_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (sel_q[ALC_B_SOL:ALC_B_POL] == 5'b00000) |-> !hit)
        else $error("limit hit with no function enabled");

    // Comparison edges: against a non-negative threshold equality never hits and a negative shunt hits only the under test;
    // a threshold past the bus range hits only the bus under test.
    shunt_sign_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (func == ALC_F_SOL && conv.shunt[15] && !thr_q[15]) |-> !hit)
        else $error("negative shunt compared above threshold");
    sul_sign_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (func == ALC_F_SUL && conv.shunt[15] && !thr_q[15]) |-> hit)
        else $error("negative shunt not below threshold");
    bus_under_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (func == ALC_F_BUL && thr_q[15]) |-> hit)
        else $error("bus not below a threshold past its range");
    bus_over_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (func == ALC_F_BOL && thr_q[15]) |-> !hit)
        else $error("bus above a threshold past its range");
    sol_eq_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (func == ALC_F_SOL && conv.shunt == thr_q) |-> !hit)
        else $error("equal shunt counted as over");
    sul_eq_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (func == ALC_F_SUL && conv.shunt == thr_q) |-> !hit)
        else $error("equal shunt counted as under");
    bol_eq_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (func == ALC_F_BOL && conv.bus == thr_q && !thr_q[15]) |-> !hit)
        else $error("equal bus counted as over");
    bul_eq_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (func == ALC_F_BUL && conv.bus == thr_q && !thr_q[15]) |-> !hit)
        else $error("equal bus counted as under");
    pol_eq_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (func == ALC_F_POL && conv.power == thr_q) |-> !hit)
        else $error("equal power counted as over");

    // Identification reads.
    maker_read_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (req.rd && (req.addr == ALC_ADDR_MAKER)) |=> (rdata_q == $past(maker_w)))
        else $error("maker code read mismatch");
    die_read_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (req.rd && (req.addr == ALC_ADDR_DIE)) |=> (rdata_q == $past(die_w)))
        else $error("die code read mismatch");

    // With no source left the transparent flag drops.
    conversion_ready_alert_enable_off_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (!sel_q[ALC_B_CONVERSION_READY_ALERT_ENABLE] && !hit_q && !sel_q[ALC_B_LATCH]) |=> !aff_q)
        else $error("alert flag held with ready alert disabled");
endmodule

/* verification/alc_host_model.sv */
// Host and converter model driving the request side of the register bank.
`timescale 1ns/1ps
module alc_host_model
    import alc_pkg::*;
(
    // Clock
    input  wire logic  core_clk,
    // Requests to the bank
    output alc_req_t   req,
    output logic       cfg_wr,
    output logic [2:0] cfg_mode,
    output alc_conv_t  conv
);
    initial begin
        req = '0;
        cfg_wr = 1'b0;
        cfg_mode = 3'h7;
        conv = '0;
    end

    // Released strobes are cleared and the other lines inverted so that no stale value can pass for a live one.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        req <= {wr, ~wr, a, d};
        @(posedge core_clk);
        req <= {2'b00, ~a, ~d};
    endtask

    task automatic convert(input logic ovf, input logic [15:0] s, b, p);
        @(posedge core_clk);
        conv <= {1'b1, ovf, s, b, p};
        @(posedge core_clk);
        conv <= {1'b0, ~ovf, ~s, ~b, ~p};
    endtask

    task automatic config_write(input logic [2:0] m);
        @(posedge core_clk);
        cfg_wr <= 1'b1;
        cfg_mode <= m;
        @(posedge core_clk);
        cfg_wr <= 1'b0;
        cfg_mode <= ~m;
    endtask
endmodule

/* verification/alc_regs_test.sv */
// Self-checking bench for the alert, limit and calibration register bank.
`timescale 1ns/1ps
module alc_regs_test
    import alc_pkg::*;
;
    logic        core_clk = 1'b0;
    logic        sys_rst  = 1'b1;
    alc_req_t    req;
    logic        cfg_wr;
    logic [2:0]  cfg_mode;
    alc_conv_t   conv;
    logic [15:0] rdata_q;
    logic        conv_restart_q;
    logic        alert_q;
    logic [14:0] calibration_value_q;
    logic [15:0] exp_q[$];
    logic        rd_seen  = 1'b0;
    int          fails = 0;
    int          total_checks = 0;
    int          seed = 21663;
    logic [15:0] v;
    logic [47:0] lim[5] = '{48'h2000_1000_1000, 48'hff00_1000_1000, 48'h1000_2000_1000,
                            48'h1000_0800_1000, 48'h1000_1000_2000};
    localparam logic [15:0] EQ = 16'h1000;

    always #4 core_clk = ~core_clk;

    alc_regs i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .req(req), .rdata_q(rdata_q),
        .cfg_wr(cfg_wr), .cfg_mode(cfg_mode), .conv(conv), .conv_restart_q(conv_restart_q),
        .alert_q(alert_q), .calibration_value_q(calibration_value_q));
    alc_host_model i_host (.core_clk(core_clk), .req(req), .cfg_wr(cfg_wr),
        .cfg_mode(cfg_mode), .conv(conv));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Read data lands one cycle after the strobe is taken.
    always @(posedge core_clk) begin
        rd_seen <= req.rd;
        if (rd_seen) begin
            check(rdata_q, exp_q.pop_front());
        end
    end

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        i_host.bus(1'b0, a, 16'h0000);
    endtask

    task automatic alert_is(input logic e);
        repeat (3) @(posedge core_clk);
        #1;
        check({15'h0000, alert_q}, {15'h0000, e});
    endtask

    task automatic conv_alert(input logic [15:0] s, b, p, input logic e);
        i_host.convert(1'b0, s, b, p);
        alert_is(e);
    endtask

    initial begin
        repeat (5000) @(posedge core_clk);
        fails++;
        summarize();
    end

    initial begin
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd_chk(ALC_ADDR_CAL, 16'h0000);
        rd_chk(ALC_ADDR_SEL, 16'h0000);
        rd_chk(ALC_ADDR_THR, 16'h0000);
        rd_chk(ALC_ADDR_MAKER, 16'h0a5a);
        rd_chk(ALC_ADDR_DIE, 16'h1231);
        rd_chk(8'h42, 16'h0000);
        alert_is(1'b1);
        $display("Test reset values done");
        v = 16'($random(seed));
        i_host.bus(1'b1, ALC_ADDR_CAL, v);
        i_host.bus(1'b1, ALC_ADDR_MAKER, ~v);
        rd_chk(ALC_ADDR_CAL, v);
        rd_chk(ALC_ADDR_MAKER, 16'h0a5a);
        check({1'b0, calibration_value_q}, {1'b0, v[14:0]});
        $display("Test calibration done");
        i_host.bus(1'b1, ALC_ADDR_THR, EQ);
        for (int i = 0; i < 5; i++) begin
            i_host.bus(1'b1, ALC_ADDR_SEL, 16'h8000 >> i);
            conv_alert(lim[i][47:32], lim[i][31:16], lim[i][15:0], 1'b0);
            conv_alert(EQ, EQ, EQ, 1'b1);
        end
        i_host.bus(1'b1, ALC_ADDR_SEL, 16'h2000);
        conv_alert(EQ, 16'h8fff, EQ, 1'b1);
        i_host.bus(1'b1, ALC_ADDR_SEL, 16'h8800);
        conv_alert(16'h0800, EQ, 16'h2000, 1'b1);
        $display("Test limit functions done");
        i_host.bus(1'b1, ALC_ADDR_SEL, 16'h0400);
        conv_alert(EQ, EQ, EQ, 1'b0);
        rd_chk(ALC_ADDR_SEL, 16'h0418);
        rd_chk(ALC_ADDR_SEL, 16'h0400);
        alert_is(1'b1);
        i_host.convert(1'b1, EQ, EQ, EQ);
        i_host.config_write(ALC_MODE_OFF_B);
        #1;
        check({15'h0000, conv_restart_q}, 16'h0001);
        rd_chk(ALC_ADDR_SEL, 16'h041c);
        i_host.convert(1'b0, EQ, EQ, EQ);
        i_host.config_write(3'h7);
        alert_is(1'b1);
        rd_chk(ALC_ADDR_SEL, 16'h0400);
        $display("Test ready flag done");
        i_host.bus(1'b1, ALC_ADDR_SEL, 16'h8001);
        conv_alert(16'h2000, EQ, EQ, 1'b0);
        conv_alert(EQ, EQ, EQ, 1'b0);
        rd_chk(ALC_ADDR_SEL, 16'h8019);
        alert_is(1'b1);
        i_host.bus(1'b1, ALC_ADDR_SEL, 16'h8002);
        conv_alert(16'h2000, EQ, EQ, 1'b1);
        conv_alert(EQ, EQ, EQ, 1'b0);
        $display("Test latch and sense done");
        repeat (4) @(posedge core_clk);
        summarize();
    end
endmodule
